// file: omc_pkg.sv
// Purpose: constants and types shared by the operating mode controller
// Assumes: ref_clk at 25 MHz stands in for the fast rc oscillator clock
// Notes:   warm-up counts are expressed in fast oscillator clocks
package omc_pkg;
   // register offsets of the plain register port
   localparam logic [3:0] OMC_OFS_OSC_MODE  = 4'h0;  // oscillator_mode_register
   localparam logic [3:0] OMC_OFS_P1_WAKE   = 4'h1;  // port1_wake_mask
   localparam logic [3:0] OMC_OFS_STATUS    = 4'h2;  // current mode code in bits 2 to 0
   // field positions of the oscillator mode register
   localparam int OMC_BIT_FAST_STOP   = 1;
   localparam int OMC_BIT_SLOW_SEL    = 2;
   localparam int OMC_BIT_SLEEP_REQ   = 3;
   localparam int OMC_BIT_IDLE_REQ    = 4;
   // values after reset
   localparam logic [7:0] OMC_OSC_MODE_RST = 8'h00;
   localparam logic [7:0] OMC_P1_WAKE_RST  = 8'h00;
   // warm-up lengths in fast oscillator clocks
   localparam int OMC_RESET_WARMUP_CLKS = 2048;
   localparam int OMC_WAKE_WARMUP_CLKS  = 32;
   // slow mode instruction divider
   localparam int OMC_SLOW_DIV = 4;
   // cpu run-mode field encodings
   localparam logic [1:0] OMC_RUN_NORMAL = 2'b00;
   localparam logic [1:0] OMC_RUN_SLEEP  = 2'b01;
   localparam logic [1:0] OMC_RUN_GREEN  = 2'b10;
   // operating states
   typedef enum logic [2:0] {
      OMC_ST_RESET_WARM,
      OMC_ST_NORMAL,
      OMC_ST_SLOW,
      OMC_ST_GREEN,
      OMC_ST_POWER_DOWN,
      OMC_ST_WAKE_WARM
   } omc_state_type;
endpackage

// file: omc_wake_if.sv
// Purpose: carries synchronised port levels to the wake detector
// Assumes: all signals on ref_clk
// Notes:   one modport per side
`timescale 1ns/1ps
`default_nettype none
interface omc_wake_if;
   logic [7:0] port0_lvl;   // synchronised port 0 levels
   logic [7:0] port1_lvl;   // synchronised port 1 levels
   logic [7:0] p1_mask;     // port 1 wake enables
   logic       arm;         // capture reference levels while low
   logic       pin_wake;    // level change seen, registered
   modport ctl (output port0_lvl, port1_lvl, p1_mask, arm, input pin_wake);
   modport det (input port0_lvl, port1_lvl, p1_mask, arm, output pin_wake);
endinterface
`default_nettype wire

// file: omc_wake_detect.sv
// Purpose: flags any level change on the wake pins since arming
// Assumes: inputs already synchronised
// Notes:   reference levels follow the pins while disarmed
`timescale 1ns/1ps
`default_nettype none
module omc_wake_detect
   import omc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // link to the controller
   omc_wake_if.det  wk
);
   logic [7:0] p0_ref_r;   // port 0 level at arming
   logic [7:0] p1_ref_r;   // port 1 level at arming
   logic       hit_r;      // registered wake flag

   // track levels while disarmed so arming starts from the live state
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         p0_ref_r <= 8'h00;
         p1_ref_r <= 8'h00;
      end
      else if (!wk.arm)
      begin
         p0_ref_r <= wk.port0_lvl;
         p1_ref_r <= wk.port1_lvl;
      end
   end

   // either edge counts; port 0 always, port 1 per mask bit
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         hit_r <= 1'b0;
      else
         hit_r <= wk.arm && (|(wk.port0_lvl ^ p0_ref_r) ||
                  |((wk.port1_lvl ^ p1_ref_r) & wk.p1_mask));
   end

   assign wk.pin_wake = hit_r;
endmodule
`default_nettype wire

// file: omc_ctrl.sv
// Purpose: operating mode controller: clock select, gating, warm-up, wake
// Assumes: ref_clk is the fast oscillator clock; register port is plain
// Notes:   clocks are modelled as enables; the slow clock arrives as a level
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module omc_ctrl
   import omc_pkg::*;
#(
   parameter int RESET_WARMUP = OMC_RESET_WARMUP_CLKS  // shorten in simulation
)
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rst,
   // register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output var  logic [7:0] reg_rdata,
   // wake sources
   input  wire logic [7:0] port0_pins,
   input  wire logic [7:0] port1_pins,
   input  wire logic       slow_osc_tick,
   input  wire logic       timer_wake_ovf,
   input  wire logic       compare_wake,
   input  wire logic       pwm_buzzer_ovf,
   // clock and execution control
   output var  logic       fast_osc_en,
   output var  logic       slow_osc_en,
   output var  logic       cpu_clk_slow_sel,
   output var  logic       cpu_run,
   output var  logic       cpu_step,
   output var  logic       timers_en,
   output var  logic       ext_irq_en,
   output var  logic       int_irq_en,
   output var  logic       wake_timer_en,
   output var  logic       pwm_buzzer_en,
   output var  logic [2:0] mode_code
);
   // cycle count derived from the warm-up figures
   localparam int WAKE_WARMUP = OMC_WAKE_WARMUP_CLKS;

   omc_state_type state_r;        // current operating state
   omc_state_type state_nxt;      // next operating state
   logic [11:0]   warm_cnt_r;     // warm-up down counter
   logic [11:0]   warm_cnt_nxt;   // next warm-up count
   logic          fast_stop_r;    // fast_osc_stop bit
   logic          slow_sel_r;     // slow_clock_select bit
   logic          sleep_req_r;    // sleep_request bit
   logic          idle_req_r;     // idle_request bit
   logic [7:0]    p1_mask_r;      // port1_wake_mask
   logic          green_from_slow_r; // mode to return to from green
   logic [7:0]    p0_s1_r;        // port 0 first sync stage
   logic [7:0]    p0_s2_r;        // port 0 second sync stage
   logic [7:0]    p1_s1_r;        // port 1 first sync stage
   logic [7:0]    p1_s2_r;        // port 1 second sync stage
   logic [2:0]    async_s1_r;     // slow tick, timer, compare first stage
   logic [2:0]    async_s2_r;     // second stage
   logic          slow_tick_d_r;  // previous synced slow tick for edge find
   logic [1:0]    slow_div_r;     // slow clock divide by four
   logic          slow_edge;      // one slow oscillator rising edge
   logic          wake_pins;      // pin level change
   logic          green_wake;     // any green mode wake cause
   logic [1:0]    run_field;      // cpu_run_mode_field view
   logic          wake_pd;        // leaving power down this cycle
   logic          wake_gr;        // leaving green this cycle
   logic          green_slow;     // green holds the slow source

   omc_wake_if wk ();

   // pins and other-domain inputs pass two flops before use
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         p0_s1_r    <= 8'h00;
         p0_s2_r    <= 8'h00;
         p1_s1_r    <= 8'h00;
         p1_s2_r    <= 8'h00;
         async_s1_r <= 3'h0;
         async_s2_r <= 3'h0;
      end
      else
      begin
         p0_s1_r    <= port0_pins;
         p0_s2_r    <= p0_s1_r;
         p1_s1_r    <= port1_pins;
         p1_s2_r    <= p1_s1_r;
         async_s1_r <= {compare_wake, timer_wake_ovf, slow_osc_tick};
         async_s2_r <= async_s1_r;
      end
   end

   // detector armed only while asleep or idle
   assign wk.port0_lvl = p0_s2_r;
   assign wk.port1_lvl = p1_s2_r;
   assign wk.p1_mask   = p1_mask_r;
   assign wk.arm       = (state_r == OMC_ST_POWER_DOWN) || (state_r == OMC_ST_GREEN);
   assign wake_pins    = wk.pin_wake;

   omc_wake_detect u_wake (
      .ref_clk (ref_clk),
      .rst     (rst),
      .wk      (wk)
   );

   // pwm and buzzer overflow is deliberately not a wake cause
   assign green_wake = wake_pins || async_s2_r[1] || async_s2_r[2];
   assign run_field  = {idle_req_r, sleep_req_r};
   assign wake_pd    = (state_r == OMC_ST_POWER_DOWN) && wake_pins;
   assign wake_gr    = (state_r == OMC_ST_GREEN) && green_wake;
   assign slow_edge  = async_s2_r[0] && !slow_tick_d_r;
   // on the entry edge the stored source is stale, so judge it from the mode being left
   assign green_slow = (state_r == OMC_ST_GREEN) ? green_from_slow_r : (state_r == OMC_ST_SLOW);

   // mode state machine
   always_comb
   begin
      state_nxt    = state_r;
      warm_cnt_nxt = warm_cnt_r;
      case (state_r)
         OMC_ST_RESET_WARM:
         begin
            // hold execution until the reset warm-up runs out
            if (warm_cnt_r == 12'h000)
               state_nxt = OMC_ST_NORMAL;
            else
               warm_cnt_nxt = warm_cnt_r - 12'h001;
         end
         OMC_ST_NORMAL, OMC_ST_SLOW:
         begin
            // field decode; reserved code leaves the mode alone
            if (run_field == OMC_RUN_SLEEP)
               state_nxt = OMC_ST_POWER_DOWN;
            else if (run_field == OMC_RUN_GREEN)
               state_nxt = OMC_ST_GREEN;
            else if (!slow_sel_r && fast_stop_r)
               state_nxt = OMC_ST_POWER_DOWN;
            else if (slow_sel_r)
               state_nxt = OMC_ST_SLOW;
            else
               state_nxt = OMC_ST_NORMAL;
         end
         OMC_ST_GREEN:
         begin
            // clock never stopped, so no warm-up on the way out
            if (green_wake)
               state_nxt = green_from_slow_r ? OMC_ST_SLOW : OMC_ST_NORMAL;
         end
         OMC_ST_POWER_DOWN:
         begin
            if (wake_pins)
            begin
               state_nxt    = OMC_ST_WAKE_WARM;
               warm_cnt_nxt = 12'(WAKE_WARMUP - 1);
            end
         end
         OMC_ST_WAKE_WARM:
         begin
            // always lands in normal whatever came before
            if (warm_cnt_r == 12'h000)
               state_nxt = OMC_ST_NORMAL;
            else
               warm_cnt_nxt = warm_cnt_r - 12'h001;
         end
         default:
            state_nxt = OMC_ST_RESET_WARM;
      endcase
   end

   // state and warm-up counter
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state_r    <= OMC_ST_RESET_WARM;
         warm_cnt_r <= 12'(OMC_RESET_WARMUP_CLKS - 1);
      end
      else
      begin
         state_r    <= state_nxt;
         warm_cnt_r <= (state_r == OMC_ST_RESET_WARM && warm_cnt_r > 12'(RESET_WARMUP - 1))
                       ? 12'(RESET_WARMUP - 1) : warm_cnt_nxt;
      end
   end

   // remember where green was entered from
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         green_from_slow_r <= 1'b0;
      else if (state_nxt == OMC_ST_GREEN && state_r != OMC_ST_GREEN)
         green_from_slow_r <= (state_r == OMC_ST_SLOW);
   end

   // oscillator mode bits; hardware clear of request bits wins over writes
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fast_stop_r <= OMC_OSC_MODE_RST[OMC_BIT_FAST_STOP];
         slow_sel_r  <= OMC_OSC_MODE_RST[OMC_BIT_SLOW_SEL];
         sleep_req_r <= OMC_OSC_MODE_RST[OMC_BIT_SLEEP_REQ];
         idle_req_r  <= OMC_OSC_MODE_RST[OMC_BIT_IDLE_REQ];
      end
      else if (wake_pd)
      begin
         sleep_req_r <= 1'b0;
         idle_req_r  <= 1'b0;
         fast_stop_r <= 1'b0;
         slow_sel_r  <= 1'b0;
      end
      else if (wake_gr)
      begin
         idle_req_r <= 1'b0;
      end
      else if (reg_wr && reg_addr == OMC_OFS_OSC_MODE)
      begin
         fast_stop_r <= reg_wdata[OMC_BIT_FAST_STOP];
         slow_sel_r  <= reg_wdata[OMC_BIT_SLOW_SEL];
         sleep_req_r <= reg_wdata[OMC_BIT_SLEEP_REQ];
         idle_req_r  <= reg_wdata[OMC_BIT_IDLE_REQ];
      end
   end

   // port 1 wake mask register
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         p1_mask_r <= OMC_P1_WAKE_RST;
      else if (reg_wr && reg_addr == OMC_OFS_P1_WAKE)
         p1_mask_r <= reg_wdata;
   end

   // slow instruction rate: one step per four slow oscillator edges
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         slow_tick_d_r <= 1'b0;
         slow_div_r    <= 2'h0;
      end
      else
      begin
         slow_tick_d_r <= async_s2_r[0];
         if (slow_edge)
            slow_div_r <= slow_div_r + 2'h1;
      end
   end

   // register read, data valid the cycle after the strobe
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         reg_rdata <= 8'h00;
      else if (reg_rd)
      begin
         if (reg_addr == OMC_OFS_OSC_MODE)
            reg_rdata <= {3'h0, idle_req_r, sleep_req_r, slow_sel_r, fast_stop_r, 1'b0};
         else if (reg_addr == OMC_OFS_STATUS)
            reg_rdata <= {5'h00, mode_code};
         else
            reg_rdata <= 8'h00;   // mask is write-only, unmapped reads zero
      end
   end

   // clock, execution and peripheral gating per mode
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fast_osc_en      <= 1'b1;
         slow_osc_en      <= 1'b1;
         cpu_clk_slow_sel <= 1'b0;
         cpu_run          <= 1'b0;
         cpu_step         <= 1'b0;
         timers_en        <= 1'b0;
         ext_irq_en       <= 1'b0;
         int_irq_en       <= 1'b0;
         wake_timer_en    <= 1'b0;
         pwm_buzzer_en    <= 1'b0;
         mode_code        <= 3'h0;
      end
      else
      begin
         mode_code <= 3'(state_nxt);
         case (state_nxt)
            OMC_ST_NORMAL:
            begin
               fast_osc_en      <= 1'b1;
               slow_osc_en      <= 1'b1;
               cpu_clk_slow_sel <= 1'b0;
               cpu_run          <= 1'b1;
               cpu_step         <= 1'b1;
               timers_en        <= 1'b1;
               ext_irq_en       <= 1'b1;
               int_irq_en       <= 1'b1;
               wake_timer_en    <= 1'b1;
               pwm_buzzer_en    <= 1'b1;
            end
            OMC_ST_SLOW:
            begin
               fast_osc_en      <= !fast_stop_r;
               slow_osc_en      <= 1'b1;
               cpu_clk_slow_sel <= 1'b1;
               cpu_run          <= 1'b1;
               cpu_step         <= slow_edge && (slow_div_r == 2'(OMC_SLOW_DIV - 1));
               timers_en        <= 1'b1;
               ext_irq_en       <= 1'b1;
               int_irq_en       <= 1'b1;
               wake_timer_en    <= 1'b1;
               pwm_buzzer_en    <= 1'b1;
            end
            OMC_ST_GREEN:
            begin
               // the slow source always runs; the fast one stops only when slow is selected and fast_osc_stop is set
               fast_osc_en      <= !fast_stop_r || !green_slow;
               slow_osc_en      <= 1'b1;
               cpu_clk_slow_sel <= green_slow;
               cpu_run          <= 1'b0;
               cpu_step         <= 1'b0;
               timers_en        <= 1'b0;
               ext_irq_en       <= 1'b1;
               int_irq_en       <= 1'b1; // wake timer interrupt only
               wake_timer_en    <= 1'b1;
               pwm_buzzer_en    <= 1'b1;
            end
            OMC_ST_POWER_DOWN:
            begin
               fast_osc_en      <= 1'b0;
               slow_osc_en      <= 1'b0;
               cpu_clk_slow_sel <= 1'b0;
               cpu_run          <= 1'b0;
               cpu_step         <= 1'b0;
               timers_en        <= 1'b0;
               ext_irq_en       <= 1'b0;
               int_irq_en       <= 1'b0;
               wake_timer_en    <= 1'b0;
               pwm_buzzer_en    <= 1'b0;
            end
            default:
            begin
               // warm-up: oscillators on, execution held
               fast_osc_en      <= 1'b1;
               slow_osc_en      <= 1'b1;
               cpu_clk_slow_sel <= 1'b0;
               cpu_run          <= 1'b0;
               cpu_step         <= 1'b0;
               timers_en        <= 1'b0;
               ext_irq_en       <= 1'b0;
               int_irq_en       <= 1'b0;
               wake_timer_en    <= 1'b0;
               pwm_buzzer_en    <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// file: omc_ctrl_sva.sv
// Purpose: port-level checks of the operating mode controller
// Assumes: mode_code 1 normal, 2 slow, 3 green, 4 power down, 5 wake warm-up
// Notes:   steady checks wait two cycles so the output lag is tolerated
`timescale 1ns/1ps
`default_nettype none
module omc_ctrl_sva
   import omc_pkg::*;
#(
   parameter int RESET_WARMUP = OMC_RESET_WARMUP_CLKS  // must match the design
)
(
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       rst,
   // watched outputs
   input wire logic       fast_osc_en,
   input wire logic       slow_osc_en,
   input wire logic       cpu_clk_slow_sel,
   input wire logic       cpu_run,
   input wire logic       timers_en,
   input wire logic       ext_irq_en,
   input wire logic       int_irq_en,
   input wire logic [2:0] mode_code
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   logic [12:0] rw_cnt_r;    // cycles since reset release, saturating
   logic [6:0]  wk_cnt_r;    // consecutive cycles spent in wake warm-up
   logic [2:0]  prev_run_r;  // last running mode, the green return target

   // saturate a little past the warm-up so the antecedent fires once
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         rw_cnt_r <= 13'h0;
      else if (int'(rw_cnt_r) < RESET_WARMUP + 4)
         rw_cnt_r <= rw_cnt_r + 13'h1;
   end

   // warm-up length counter, cleared outside the warm-up state
   always_ff @(posedge ref_clk)
   begin
      if (rst || mode_code != 3'h5)
         wk_cnt_r <= 7'h0;
      else
         wk_cnt_r <= wk_cnt_r + 7'h1;
   end

   // remember normal or slow so a green stay can be judged on exit
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         prev_run_r <= 3'h1;
      else if (mode_code == 3'h1 || mode_code == 3'h2)
         prev_run_r <= mode_code;
   end

   sequence leave_green_s;
      mode_code == 3'h3 ##1 mode_code != 3'h3;
   endsequence
   sequence leave_pd_s;
      mode_code == 3'h4 ##1 mode_code != 3'h4;
   endsequence
   sequence leave_warm_s;
      mode_code == 3'h5 ##1 mode_code != 3'h5;
   endsequence

   normal_clocks_a: assert property (mode_code == 3'h1 [*2] |-> fast_osc_en && slow_osc_en
      && cpu_run && !cpu_clk_slow_sel && ext_irq_en && int_irq_en)
      else $error("normal mode outputs wrong");
   slow_select_a: assert property (mode_code == 3'h2 [*2] |-> cpu_clk_slow_sel
      && slow_osc_en && cpu_run) else $error("slow mode outputs wrong");
   green_halt_a: assert property (mode_code == 3'h3 [*2] |-> !cpu_run && slow_osc_en
      && ext_irq_en) else $error("green mode outputs wrong");
   pd_stop_a: assert property (mode_code == 3'h4 [*2] |-> !fast_osc_en && !slow_osc_en
      && !cpu_run && !timers_en && !ext_irq_en && !int_irq_en)
      else $error("power down outputs wrong");
   reset_hold_a: assert property (int'(rw_cnt_r) < RESET_WARMUP |-> !cpu_run)
      else $error("execution before reset warm-up ended");
   reset_run_a: assert property (int'(rw_cnt_r) == RESET_WARMUP |-> ##[1:3] cpu_run)
      else $error("execution did not start after warm-up");
   wake_warm_a: assert property (leave_warm_s |-> wk_cnt_r == 7'd32)
      else $error("wake warm-up length wrong");
   pd_exit_a: assert property (leave_pd_s |-> mode_code == 3'h5)
      else $error("power down left without warm-up");
   warm_exit_a: assert property (leave_warm_s |-> mode_code == 3'h1)
      else $error("warm-up did not end in normal mode");
   green_return_a: assert property (leave_green_s |-> mode_code == prev_run_r)
      else $error("green exit went to wrong mode");
endmodule
bind omc_ctrl omc_ctrl_sva #(.RESET_WARMUP(RESET_WARMUP)) omc_ctrl_sva_inst (
   .ref_clk(ref_clk), .rst(rst), .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
   .cpu_clk_slow_sel(cpu_clk_slow_sel), .cpu_run(cpu_run), .timers_en(timers_en),
   .ext_irq_en(ext_irq_en), .int_irq_en(int_irq_en), .mode_code(mode_code));
`default_nettype wire

// file: tb_top.sv
// Purpose: self-checking bench for the operating mode controller
// Assumes: reset warm-up shortened to 8 clocks; register writes from the bench stand in for software
// Notes:   random pins, masks and bit choices come from one fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import omc_pkg::*;
   localparam int RW = 8;  // shortened reset warm-up
   logic       ref_clk, rst, reg_wr, reg_rd;      // clock, reset, strobes
   logic [3:0] reg_addr;                          // register index
   logic [7:0] reg_wdata, reg_rdata;              // register data
   logic [7:0] port0_pins, port1_pins, p1m;       // pin levels, chosen mask
   logic       slow_osc_tick, timer_wake_ovf, compare_wake, pwm_buzzer_ovf;
   logic       fast_osc_en, slow_osc_en, cpu_clk_slow_sel, cpu_run, cpu_step;
   logic       timers_en, ext_irq_en, int_irq_en, wake_timer_en, pwm_buzzer_en;
   logic [2:0] mode_code;                         // current state
   int         failures, n_tests, steps, n, b, i; // bookkeeping

   omc_ctrl #(.RESET_WARMUP(RW)) omc_ctrl_inst (.ref_clk(ref_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .port0_pins(port0_pins), .port1_pins(port1_pins),
      .slow_osc_tick(slow_osc_tick), .timer_wake_ovf(timer_wake_ovf),
      .compare_wake(compare_wake), .pwm_buzzer_ovf(pwm_buzzer_ovf),
      .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
      .cpu_clk_slow_sel(cpu_clk_slow_sel), .cpu_run(cpu_run), .cpu_step(cpu_step),
      .timers_en(timers_en), .ext_irq_en(ext_irq_en), .int_irq_en(int_irq_en),
      .wake_timer_en(wake_timer_en), .pwm_buzzer_en(pwm_buzzer_en), .mode_code(mode_code));

   // 40 ns period
   always #20 ref_clk = ~ref_clk;

   // count slow-mode instruction pulses
   always @(posedge ref_clk)
      if (cpu_step === 1'b1)
         steps++;

   task automatic finish_test();
      if (failures == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // readable bits of the oscillator mode register
   function automatic logic [7:0] osc_exp(input logic [7:0] d);
      return d & 8'h1e;
   endfunction

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data appears in the cycle after the strobe and holds until the next read
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", reg_rdata, exp);
   endtask

   // bounded wait for a state, then compare
   task automatic wait_mode(input logic [2:0] m, input int lim);
      for (int k = 0; k < lim && mode_code !== m; k++)
         @(posedge ref_clk) #1;
      chk("mode_code", {5'h0, mode_code}, {5'h0, m});
   endtask

   task automatic go(input logic [7:0] d, input logic [2:0] m);
      wr(OMC_OFS_OSC_MODE, d);
      wait_mode(m, 20);
   endtask

   // flip one pin; both edge directions occur over the run
   task automatic pin(input bit p1, input int bit_no);
      @(posedge ref_clk);
      if (p1)
         port1_pins <= port1_pins ^ (8'h01 << bit_no);
      else
         port0_pins <= port0_pins ^ (8'h01 << bit_no);
   endtask

   // two-cycle pulse: 0 wake timer, 1 comparator, 2 pwm or buzzer
   task automatic pulse(input int s);
      @(posedge ref_clk);
      timer_wake_ovf <= (s == 0);
      compare_wake   <= (s == 1);
      pwm_buzzer_ovf <= (s == 2);
      repeat (2) @(posedge ref_clk);
      {timer_wake_ovf, compare_wake, pwm_buzzer_ovf} <= 3'h0;
   endtask

   // hold reset, release, time the start of execution
   task automatic do_reset(input int len);
      rst <= 1'b1;
      repeat (len) @(posedge ref_clk);
      rst <= 1'b0;
      #1;
      chk("cpu_run", {7'h0, cpu_run}, 8'h00);
      for (n = 0; n < 5000 && cpu_run !== 1'b1; n++)
         @(posedge ref_clk) #1;
      chk("warmup", 8'(n), 8'(RW + 1));
      chk("mode_code", {5'h0, mode_code}, 8'h01);
   endtask

   // watchdog sized well above the expected run length
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      failures++;
      finish_test();
   end

   initial
   begin
      {ref_clk, reg_wr, reg_rd, slow_osc_tick} = 4'h0;
      {timer_wake_ovf, compare_wake, pwm_buzzer_ovf} = 3'h0;
      {failures, n_tests, steps} = 0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      rst = 1'b1;
      b = $urandom(82918);
      port0_pins = 8'($urandom());
      port1_pins = 8'($urandom());
      do_reset(20);
      rd(OMC_OFS_OSC_MODE, OMC_OSC_MODE_RST);
      wr(OMC_OFS_STATUS, 8'($urandom()));
      rd(OMC_OFS_STATUS, 8'h01);
      rd(4'hf, 8'h00);
      // slow mode, instruction rate and fast oscillator still on
      go(8'h04, 3'h2);
      chk("fast_osc_en", {7'h0, fast_osc_en}, 8'h01);
      steps = 0;
      repeat (16)
      begin
         repeat (3) @(posedge ref_clk);
         slow_osc_tick <= 1'b1;
         repeat (3) @(posedge ref_clk);
         slow_osc_tick <= 1'b0;
      end
      repeat (8) @(posedge ref_clk);
      chk("cpu_step", 8'(steps), 8'(16 / OMC_SLOW_DIV));
      go(8'h06, 3'h2);
      repeat (2) @(posedge ref_clk) #1;
      chk("fast_osc_en", {7'h0, fast_osc_en}, 8'h00);
      // green from slow, pwm overflow ignored, returns to slow
      go(8'h16, 3'h3);
      pulse(2);
      repeat (4) @(posedge ref_clk);
      wait_mode(3'h3, 10);
      pin(1'b0, $urandom_range(7, 0));
      wait_mode(3'h2, 20);
      rd(OMC_OFS_OSC_MODE, osc_exp(8'h06));
      // power down from slow: timer and masked-out port 1 pin ignored
      b = $urandom_range(7, 0);
      p1m = 8'($urandom()) & ~(8'h01 << b);
      wr(OMC_OFS_P1_WAKE, p1m);
      go(8'h0e, 3'h4);
      pulse(0);
      pin(1'b1, b);
      repeat (6) @(posedge ref_clk);
      wait_mode(3'h4, 10);
      pin(1'b0, $urandom_range(7, 0));
      wait_mode(3'h5, 10);
      for (n = 0; n < 100 && mode_code === 3'h5; n++)
         @(posedge ref_clk) #1;
      chk("wake_warm", 8'(n), 8'(OMC_WAKE_WARMUP_CLKS));
      wait_mode(3'h1, 5);
      rd(OMC_OFS_OSC_MODE, 8'h00);
      // fast stop in normal sleeps; an unmasked port 1 pin wakes it
      wr(OMC_OFS_P1_WAKE, p1m | (8'h01 << b));
      go(8'h02, 3'h4);
      pin(1'b1, b);
      wait_mode(3'h1, 60);
      chk("cpu_run", {7'h0, cpu_run}, 8'h01);
      // green from normal, each wake source in turn
      for (i = 0; i < 4; i++)
      begin
         go(8'h10, 3'h3);
         pulse(2);
         repeat (4) @(posedge ref_clk);
         wait_mode(3'h3, 8);
         chk("wake_timer_en", {7'h0, wake_timer_en}, 8'h01);
         chk("pwm_buzzer_en", {7'h0, pwm_buzzer_en}, 8'h01);
         if (i < 2)
            pin(i[0], b);
         else
            pulse(i - 2);
         wait_mode(3'h1, 20);
         rd(OMC_OFS_OSC_MODE, 8'h00);
      end
      // reserved run-field code leaves the mode alone
      wr(OMC_OFS_OSC_MODE, 8'h18);
      repeat (10) @(posedge ref_clk);
      wait_mode(3'h1, 1);
      wr(OMC_OFS_OSC_MODE, 8'h00);
      do_reset(2);
      finish_test();
   end
endmodule
`default_nettype wire
